// *** gpb_pad_model.sv ***
/*
 gpb_pad_model: board side of the 29 gpio pads, ports packed {p3,p2,p1,p0}.
 assumes the bench sets board values and enables; device drive wins a fight.
*/
`timescale 1ns/1ps
module gpb_pad_model (
	// clock
	input  wire logic        clk_sys,
	// device side
	input  wire logic [28:0] pinOut,
	input  wire logic [28:0] pinOe,
	input  wire logic [28:0] pullEn,
	// board side
	input  wire logic [28:0] boardVal,
	input  wire logic [28:0] boardEn,
	output logic      [28:0] pinLevel
);
	// a pin nobody holds toggles, so a lucky settle never passes
	logic tgl_q = 1'b0;
	always_ff @(posedge clk_sys) begin
		tgl_q <= ~tgl_q;
	end
	// released open drain falls to board or pull-up
	assign pinLevel = (pinOe & pinOut) | (~pinOe & boardEn & boardVal)
		| (~pinOe & ~boardEn & (pullEn | {29{tgl_q}}) & (pullEn | ~pullEn & {29{tgl_q}}));
endmodule // gpb_pad_model

// *** gpb_pkg.sv ***
/*
 gpb_pkg: register map, field masks and reset values of the gpio port bank.
 assumes a 32-bit apb master on the same clock; one aligned word per register.
*/
package gpb_pkg;
	// per-port register block, ports at a fixed stride
	localparam logic [11:0] PORT_STRIDE = 12'h020;
	localparam logic [11:0] MAP_END     = 12'h080;
	localparam logic [2:0]  REG_OUT     = 3'h0;
	localparam logic [2:0]  REG_DIR     = 3'h1;
	localparam logic [2:0]  REG_PULL    = 3'h2;
	localparam logic [2:0]  REG_DRV     = 3'h3;
	localparam logic [2:0]  REG_IN      = 3'h4;
	localparam logic [2:0]  REG_IEN     = 3'h5;
	localparam logic [2:0]  REG_IST     = 3'h6;
	localparam int          PORT_LSB    = 5;
	localparam int          REG_LSB     = 2;
	localparam int          NPORT       = 4;
	// pins that exist: port 3 has bits 0-4 only
	localparam logic [3:0][7:0] IMPL_MASK  = {8'h1f, 8'hff, 8'hff, 8'hff};
	// pins that can be read: port 1 bit 5 is output only
	localparam logic [3:0][7:0] INPUT_MASK = {8'h1f, 8'hff, 8'hdf, 8'hff};
	// interrupt sources: ports 0 and 1 only
	localparam logic [3:0][7:0] IRQ_MASK   = {8'h00, 8'h00, 8'hdf, 8'hff};
	// direction bits that are held at output
	localparam logic [3:0][7:0] DIR_FORCE  = {8'h00, 8'h00, 8'h20, 8'h00};
	localparam logic [7:0]      OUT_RST    = 8'h00;
	localparam logic [7:0]      PULL_RST   = 8'h00;
	localparam logic [7:0]      DRV_RST    = 8'h00;
	localparam logic [7:0]      IEN_RST    = 8'h00;
	localparam logic [3:0][7:0] DIR_RST    = DIR_FORCE;
endpackage

// *** gpb_port_bank.sv ***
/*
 gpb_port_bank: four gpio ports (8, 8, 8, 5 pins) with per-pin direction,
 pull-up and driver type, apb register access and two port interrupt lines.
 assumes pads resolve level from out/oe/pull and return the pin level asynchronously.
*/
// The implementer's own choices: the register offsets and the APB interface to the registers.
// What this block does
// RL1: each pin has its own direction bit, input only or input/output.
// RL2: each pin has its own static pull-up enable bit.
// RL3: each pin selects open-drain or push-pull drive when outputting.
// RL4: port 0 raises an interrupt from any of its pins 0-7.
// RL5: each interrupt pin has its own enable; masked pins never assert it.
// RL6: port 1 matches port 0 features except where a bit differs.
// RL7: port 1 bit 5 is output only and drives low after reset.
// RL8: ports 2 and 3 have the same configuration but no interrupts.
// RL9: port 3 implements bits 0-4 only; bits 5-7 do not exist.
// RL10: unimplemented port 3 bits read zero and ignore writes.
`timescale 1ns/1ps
module gpb_port_bank (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// port 0 pads
	input  wire logic [7:0]  port0PinsIn,
	output logic      [7:0]  port0PinsOut,
	output logic      [7:0]  port0PinsOe,
	output logic      [7:0]  port0PullEn,
	// port 1 pads, bit 5 is the output-only pin
	input  wire logic [7:0]  port1PinsIn,
	output logic      [7:0]  port1PinsOut,
	output logic      [7:0]  port1PinsOe,
	output logic      [7:0]  port1PullEn,
	// port 2 pads
	input  wire logic [7:0]  port2PinsIn,
	output logic      [7:0]  port2PinsOut,
	output logic      [7:0]  port2PinsOe,
	output logic      [7:0]  port2PullEn,
	// port 3 pads, bits 0-4
	input  wire logic [4:0]  port3PinsIn,
	output logic      [4:0]  port3PinsOut,
	output logic      [4:0]  port3PinsOe,
	output logic      [4:0]  port3PullEn,
	// interrupt lines
	output logic             port0Irq,
	output logic             port1Irq
);

	logic [3:0][7:0] outQ;
	logic [3:0][7:0] dirQ;
	logic [3:0][7:0] pullQ;
	logic [3:0][7:0] drvQ;
	logic [3:0][7:0] ienQ;
	logic [3:0][7:0] statQ;
	logic [3:0][7:0] syncAQ;
	logic [3:0][7:0] syncBQ;
	logic [3:0][7:0] prevQ;
	logic [3:0][7:0] rawIn;
	logic [3:0][7:0] inLvl;
	logic [3:0][7:0] rise;
	logic [3:0][7:0] pinOe;
	logic [31:0]     rdD;
	logic [31:0]     prdataQ;
	logic            errD;
	logic            errQ;
	logic            mapped;
	logic            setupPh;
	logic            wrAcc;
	logic [1:0]      selPort;
	logic [2:0]      selReg;
	logic [7:0]      wrByte;

	assign selPort = paddr[gpb_pkg::PORT_LSB +: 2];
	assign selReg  = paddr[gpb_pkg::REG_LSB +: 3];
	assign mapped  = (paddr < gpb_pkg::MAP_END) && (paddr[1:0] == 2'h0) && (selReg != 3'h7);
	assign setupPh = psel && !penable;
	assign wrAcc   = psel && penable && pwrite && mapped;
	assign wrByte  = pwdata[7:0] & gpb_pkg::IMPL_MASK[selPort]; // [RL10]

	// configuration registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < gpb_pkg::NPORT; p++) begin
				outQ[p]  <= gpb_pkg::OUT_RST; // [RL7]
				pullQ[p] <= gpb_pkg::PULL_RST;
				drvQ[p]  <= gpb_pkg::DRV_RST;
				ienQ[p]  <= gpb_pkg::IEN_RST;
			end
			dirQ <= gpb_pkg::DIR_RST;
		end else if (wrAcc) begin
			unique case (selReg)
				gpb_pkg::REG_OUT:  outQ[selPort]  <= wrByte;
				gpb_pkg::REG_DIR:  dirQ[selPort]  <= wrByte | gpb_pkg::DIR_FORCE[selPort]; // [RL1] [RL7]
				gpb_pkg::REG_PULL: pullQ[selPort] <= wrByte; // [RL2]
				gpb_pkg::REG_DRV:  drvQ[selPort]  <= wrByte; // [RL3]
				gpb_pkg::REG_IEN:  ienQ[selPort]  <= wrByte & gpb_pkg::IRQ_MASK[selPort]; // [RL5] [RL8]
				default: ;
			endcase
		end
	end

	// pad inputs pass two flops; unimplemented bits tie low
	assign rawIn = {3'h0, port3PinsIn, port2PinsIn, port1PinsIn, port0PinsIn};

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syncAQ <= '0;
			syncBQ <= '0;
			prevQ  <= '0;
		end else begin
			syncAQ <= rawIn;
			syncBQ <= syncAQ;
			prevQ  <= syncBQ;
		end
	end

	assign inLvl = syncBQ & gpb_pkg::INPUT_MASK; // [RL7] [RL9]
	assign rise  = syncBQ & ~prevQ & gpb_pkg::IRQ_MASK; // [RL4] [RL6] [RL8]

	// sticky rising-edge status, write one to clear; a new edge beats the clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			statQ <= '0;
		end else begin
			for (int p = 0; p < gpb_pkg::NPORT; p++) begin
				if (wrAcc && selReg == gpb_pkg::REG_IST && selPort == 2'(p)) begin
					statQ[p] <= (statQ[p] & ~pwdata[7:0]) | rise[p];
				end else begin
					statQ[p] <= statQ[p] | rise[p];
				end
			end
		end
	end

	assign port0Irq = |(statQ[0] & ienQ[0]); // [RL4] [RL5]
	assign port1Irq = |(statQ[1] & ienQ[1]); // [RL6] [RL5]

	// open-drain drives only the low level; push-pull drives both
	assign pinOe = dirQ & (drvQ | ~outQ) & gpb_pkg::IMPL_MASK; // [RL1] [RL3]

	assign port0PinsOut = outQ[0];
	assign port0PinsOe  = pinOe[0];
	assign port0PullEn  = pullQ[0]; // [RL2]
	assign port1PinsOut = outQ[1];
	assign port1PinsOe  = pinOe[1];
	assign port1PullEn  = pullQ[1];
	assign port2PinsOut = outQ[2];
	assign port2PinsOe  = pinOe[2];
	assign port2PullEn  = pullQ[2];
	assign port3PinsOut = outQ[3][4:0]; // [RL9]
	assign port3PinsOe  = pinOe[3][4:0];
	assign port3PullEn  = pullQ[3][4:0];

	// read mux; data is captured in the setup cycle so prdata is a flop
	always_comb begin
		rdD  = 32'h0;
		errD = !mapped;
		if (mapped) begin
			unique case (selReg)
				gpb_pkg::REG_OUT:  rdD[7:0] = outQ[selPort];
				gpb_pkg::REG_DIR:  rdD[7:0] = dirQ[selPort];
				gpb_pkg::REG_PULL: rdD[7:0] = pullQ[selPort];
				gpb_pkg::REG_DRV:  rdD[7:0] = drvQ[selPort];
				gpb_pkg::REG_IN:   rdD[7:0] = inLvl[selPort];
				gpb_pkg::REG_IEN:  rdD[7:0] = ienQ[selPort];
				gpb_pkg::REG_IST:  rdD[7:0] = statQ[selPort];
				default:           rdD = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdataQ <= 32'h0;
			errQ    <= 1'b0;
		end else if (setupPh) begin
			prdataQ <= pwrite ? 32'h0 : rdD;
			errQ    <= errD;
		end
	end

	// one access cycle, no wait states
	assign pready  = 1'b1;
	assign prdata  = prdataQ;
	assign pslverr = psel && penable && errQ;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_dir_write;
		psel && penable && pwrite && mapped && selReg == gpb_pkg::REG_DIR;
	endsequence

	a_dir_gates_oe: assert property (((pinOe & ~dirQ) == '0)) else $error("oe without output dir"); // [RL1]
	a_dir_write_own: assert property (s_dir_write |=> (dirQ[$past(selPort)]
		== ($past(wrByte) | gpb_pkg::DIR_FORCE[$past(selPort)]))) else $error("dir write wrong"); // [RL1]
	a_pull_follows: assert property (psel && penable && pwrite && mapped && selReg == gpb_pkg::REG_PULL
		&& selPort == 2'h2 |=> port2PullEn == $past(wrByte)) else $error("pull not applied"); // [RL2]
	a_od_no_high: assert property (((pinOe & ~drvQ & outQ) == '0)) else $error("open drain drove high"); // [RL3]
	// an enable write in the same cycle may legally mask the new edge
	a_port0_edge_irq: assert property ((rise[0] & ienQ[0]) != 8'h0
		&& !(wrAcc && selReg == gpb_pkg::REG_IEN && selPort == 2'h0) |=> port0Irq)
		else $error("port0 edge lost"); // [RL4]
	a_masked_silent: assert property (ienQ[0] == 8'h0 && ienQ[1] == 8'h0 |-> !port0Irq && !port1Irq)
		else $error("masked pin raised irq"); // [RL5]
	a_port1_status: assert property ((!prevQ[1][0] && syncBQ[1][0]) |=> statQ[1][0])
		else $error("port1 edge not latched"); // [RL6]
	a_pin5_output: assert property (dirQ[1][5] && !inLvl[1][5] && !statQ[1][5])
		else $error("port1 bit5 not output only"); // [RL7]
	a_pin5_reset_low: assert property ($rose(rst_b) |-> !port1PinsOut[5] && port1PinsOe[5])
		else $error("port1 bit5 not low after reset"); // [RL7]
	a_no_irq_p23: assert property (statQ[2] == 8'h0 && statQ[3] == 8'h0 && ienQ[2] == 8'h0)
		else $error("port 2/3 interrupt state"); // [RL8]
	a_port3_upper: assert property (((outQ[3] | dirQ[3] | pullQ[3] | drvQ[3]) & 8'he0) == 8'h0)
		else $error("port3 upper bits stored"); // [RL9]
	a_unimpl_read: assert property (psel && !penable && !pwrite && selPort == 2'h3
		|=> prdata[7:5] == 3'h0) else $error("port3 upper bits read nonzero"); // [RL10]

endmodule // gpb_port_bank

// *** gpb_port_bank_tb.sv ***
/*
 gpb_port_bank_tb: random register and pin traffic on all four ports.
 assumes the pad model stands on every pin and apb answers by pready.
*/
`timescale 1ns/1ps
module gpb_port_bank_tb;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	logic [28:0] bv = '0, be = '0;
	logic [7:0]  o, d, u, e, r, x, dd;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq0, irq1;
	wire  [28:0] dOut, dOe, dPu, lvl;
	int          num_errors = 0, total_checks = 0;
	always #5 clk_sys = ~clk_sys;
	gpb_port_bank DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port0Irq(irq0), .port1Irq(irq1),
		.port0PinsIn(lvl[7:0]), .port0PinsOut(dOut[7:0]), .port0PinsOe(dOe[7:0]),
		.port0PullEn(dPu[7:0]), .port1PinsIn(lvl[15:8]), .port1PinsOut(dOut[15:8]),
		.port1PinsOe(dOe[15:8]), .port1PullEn(dPu[15:8]), .port2PinsIn(lvl[23:16]),
		.port2PinsOut(dOut[23:16]), .port2PinsOe(dOe[23:16]), .port2PullEn(dPu[23:16]),
		.port3PinsIn(lvl[28:24]), .port3PinsOut(dOut[28:24]), .port3PinsOe(dOe[28:24]),
		.port3PullEn(dPu[28:24]));
	gpb_pad_model PADS (.clk_sys(clk_sys), .pinOut(dOut), .pinOe(dOe), .pullEn(dPu),
		.boardVal(bv), .boardEn(be), .pinLevel(lvl));
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 8);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			wrap_up();
		end
	endtask
	function automatic logic [11:0] ad(input int p, input logic [2:0] rg);
		return 12'(p) * gpb_pkg::PORT_STRIDE + {7'h00, rg, 2'h0};
	endfunction
	function automatic logic [28:0] ins(input logic [28:0] v, input int p, input logic [7:0] b);
		return (v & ~(29'h0000ff << (8 * p))) | (29'(b) << (8 * p));
	endfunction
	function automatic logic [7:0] pb(input logic [28:0] v, input int p);
		return 8'(v >> (8 * p));
	endfunction
	initial begin
		rd = $urandom(41);
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk(32'(dOe), 32'h00002000);
		chk(32'(dOut), 32'h00000000);
		for (int p = 0; p < 4; p++) begin
			for (int k = 0; k < 3; k++) begin
				{o, d, u, e} = (k == 0) ? 32'hff00ffff : $urandom;
				{x, r} = 16'($urandom);
				u = u | ~r;
				apb(1'b1, ad(p, gpb_pkg::REG_OUT), {24'h0, o});
				apb(1'b1, ad(p, gpb_pkg::REG_DIR), {24'h0, d});
				apb(1'b1, ad(p, gpb_pkg::REG_PULL), {24'h0, u});
				apb(1'b1, ad(p, gpb_pkg::REG_DRV), {24'h0, e});
				bv <= ins(bv, p, x);
				be <= ins(be, p, r);
				dd = (d | gpb_pkg::DIR_FORCE[p]) & (e | ~o) & gpb_pkg::IMPL_MASK[p];
				apb(1'b0, ad(p, gpb_pkg::REG_DIR), '0);
				chk(rd, (d | gpb_pkg::DIR_FORCE[p]) & gpb_pkg::IMPL_MASK[p]);
				apb(1'b0, ad(p, gpb_pkg::REG_PULL), '0);
				chk(rd, u & gpb_pkg::IMPL_MASK[p]);
				apb(1'b0, ad(p, gpb_pkg::REG_DRV), '0);
				chk(rd, e & gpb_pkg::IMPL_MASK[p]);
				chk(pb(dOe, p), dd);
				chk(pb(dPu, p), u & gpb_pkg::IMPL_MASK[p]);
				apb(1'b0, ad(p, gpb_pkg::REG_OUT), '0);
				chk(rd, o & gpb_pkg::IMPL_MASK[p]);
				chk(pb(dOut, p), o & gpb_pkg::IMPL_MASK[p]);
				apb(1'b0, ad(p, gpb_pkg::REG_IN), '0);
				chk(rd, ((dd & o) | (~dd & r & x) | (~dd & ~r & u)) & gpb_pkg::INPUT_MASK[p]);
			end
			$display("config test port %0d done", p);
		end
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, ad(p, gpb_pkg::REG_DIR), '0);
			be <= ins(be, p, 8'hff);
			bv <= ins(bv, p, 8'h00);
			{e, r} = 16'($urandom);
			apb(1'b1, ad(p, gpb_pkg::REG_IST), 32'h000000ff);
			apb(1'b1, ad(p, gpb_pkg::REG_IEN), {24'h0, e});
			bv <= ins(bv, p, r);
			// rising pin sets status on the third edge, irq in the same cycle
			repeat (5) @(posedge clk_sys);
			chk(32'({irq1, irq0}), 32'(|(r & e & gpb_pkg::IRQ_MASK[p])) << p);
			apb(1'b0, ad(p, gpb_pkg::REG_IST), '0);
			chk(rd, r & gpb_pkg::IRQ_MASK[p]);
			apb(1'b0, ad(p, gpb_pkg::REG_IEN), '0);
			chk(rd, e & gpb_pkg::IRQ_MASK[p]);
			apb(1'b1, ad(p, gpb_pkg::REG_IST), 32'h000000ff);
			@(posedge clk_sys);
			chk(32'({irq1, irq0}), 32'h0);
			$display("interrupt test port %0d done", p);
		end
		// unused index, past the map end, misaligned byte address
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, (i == 0) ? ad(0, 3'h7) : ((i == 1) ? 12'h080 : 12'h042), '0);
			chk({31'h0, err}, 32'h1);
			chk(rd, 32'h0);
		end
		$display("unmapped test done");
		wrap_up();
	end
endmodule // gpb_port_bank_tb
